// ===== rtl/gpcfg_pkg.sv
// Shared constants for the pin configuration block
package gpcfg_pkg;
	localparam int          GPCFG_NREG        = 10;
	localparam int          GPCFG_NPIN        = 11;
	localparam int          GPCFG_AW          = 8;
	// Register offsets
	localparam logic [7:0]  PORT0_PIN7_CONFIG = 8'h0C;
	localparam logic [7:0]  PORT1_PIN0_CONFIG = 8'h0D;
	localparam logic [7:0]  PORT1_PIN1_CONFIG = 8'h0E;
	localparam logic [7:0]  PORT1_PIN2_CONFIG = 8'h0F;
	localparam logic [7:0]  PORT1_PIN3_CONFIG = 8'h10;
	localparam logic [7:0]  PORT1_PIN4_CONFIG = 8'h11;
	localparam logic [7:0]  PORT1_PIN5_CONFIG = 8'h12;
	localparam logic [7:0]  PORT1_PIN6_CONFIG = 8'h13;
	localparam logic [7:0]  PORT1_PIN7_CONFIG = 8'h14;
	localparam logic [7:0]  PORT2_PAIR_CONFIG = 8'h15;
	localparam logic [7:0]  GPCFG_RESET       = 8'h00;
	// Field positions
	localparam int          F_OE              = 0;
	localparam int          F_PULLUP          = 1;
	localparam int          F_OPEN_DRAIN      = 2;
	localparam int          F_HIGH_SINK       = 3;
	localparam int          F_TTL             = 4;
	localparam int          F_INT_LOW         = 5;
	localparam int          F_INT_EN          = 6;
	localparam int          F_TOP             = 7;
	// Writable bits per register, index = offset - first offset
	localparam logic [7:0]  GPCFG_MASK [GPCFG_NREG] = '{
		8'h77, 8'h63, 8'h65, 8'hFF, 8'h6F, 8'hEF, 8'hEF, 8'hEF, 8'h6F, 8'h7F};
	// Serial engine communication modes
	localparam logic [1:0]  COMM_OFF          = 2'h0;
	localparam logic [1:0]  COMM_MASTER       = 2'h1;
	localparam logic [1:0]  COMM_SLAVE        = 2'h2;
endpackage : gpcfg_pkg

// ===== rtl/gpcfg_top.sv
// Pin configuration registers and pin drive logic for the general purpose pins
`timescale 1ns/1ns
// How it works
// - Port1_pin0 only pulls low or releases
// - Shared pull-up bit for port1_pin0 and pin1
// - Bit 7 routes selected clock onto port1_pin2
// - Port1_pin3 to pin7 always TTL threshold
// - Serial engine owns port1_pin3 while enabled
// - Pins 4-6 serial only with engine and flag
// - Interrupt, sink, drain, pull-up apply in serial use
// - Engine sets direction of pins 3, 5, 6
// - Port0_pin7 register field layout
// - Port1_pin1 register field layout
// - One register governs both port 2 pins
// - Port1_pin7 register field layout
// - Interrupt enable allows edge interrupt any direction
// - Polarity bit selects rising or falling edge
// - Open drain: one releases, zero drives low
// - Output enable switches the pin driver
module gpcfg_top
	import gpcfg_pkg::*;
(
	input  wire logic                               clock,
	input  wire logic                               resetn,
	input  wire logic [gpcfg_pkg::GPCFG_AW-1:0]     reg_addr,
	input  wire logic [7:0]                         reg_wdata,
	input  wire logic                               reg_wr,
	input  wire logic                               reg_rd,
	output logic      [7:0]                         reg_rdata,
	input  wire logic [gpcfg_pkg::GPCFG_NPIN-1:0]   pin_data,
	input  wire logic [gpcfg_pkg::GPCFG_NPIN-1:0]   pin_in,
	input  wire logic [1:0]                         serial_mode,
	input  wire logic [3:0]                         serial_out,
	input  wire logic [3:0]                         serial_oe,
	input  wire logic                               clock_select_out,
	output logic      [gpcfg_pkg::GPCFG_NPIN-1:0]   pin_out,
	output logic      [gpcfg_pkg::GPCFG_NPIN-1:0]   pin_oe,
	output logic      [gpcfg_pkg::GPCFG_NPIN-1:0]   pin_pullup,
	output logic      [gpcfg_pkg::GPCFG_NPIN-1:0]   pin_ttl,
	output logic      [gpcfg_pkg::GPCFG_NPIN-1:0]   pin_high_sink,
	output logic      [gpcfg_pkg::GPCFG_NPIN-1:0]   pin_irq
);
	import gpcfg_pkg::*;

	// Pin index map; port 2 pins sit at the top
	localparam int IDX_PORT0_PIN7 = 0;
	localparam int IDX_PORT1_PIN0 = 1;
	localparam int IDX_PORT1_PIN1 = 2;
	localparam int IDX_PORT1_PIN2 = 3;
	localparam int IDX_PORT1_PIN3 = 4;
	localparam int IDX_PORT1_PIN4 = 5;
	localparam int IDX_PORT1_PIN5 = 6;
	localparam int IDX_PORT1_PIN6 = 7;
	localparam int IDX_PORT1_PIN7 = 8;
	localparam int IDX_PORT2_PIN0 = 9;
	localparam int IDX_PORT2_PIN1 = 10;
	// Engine lanes run from port1_pin3 to port1_pin6
	localparam int ENG_FIRST      = IDX_PORT1_PIN3;
	localparam int ENG_LAST       = IDX_PORT1_PIN6;

	// Who drives a pin, Gray coded along the usual order
	typedef enum logic [1:0] {
		SRC_FIRMWARE = 2'h0,
		SRC_ENGINE   = 2'h1,
		SRC_CLOCK    = 2'h3
	} gpcfg_src_type;

	// Register file and read path
	logic [7:0]             cfg_r     [GPCFG_NREG];
	logic [7:0]             cfg_nxt   [GPCFG_NREG];
	logic [7:0]             rdata_r;
	logic [7:0]             rdata_nxt;

	// Edge detector state
	logic [GPCFG_NPIN-1:0]  prev_r;
	logic [GPCFG_NPIN-1:0]  prev_nxt;
	logic [GPCFG_NPIN-1:0]  rise_seen;
	logic [GPCFG_NPIN-1:0]  fall_seen;
	logic [GPCFG_NPIN-1:0]  irq_r;
	logic [GPCFG_NPIN-1:0]  irq_nxt;

	// Bus decode
	logic [7:0]             rel_addr;
	logic                   addr_hit;
	logic [3:0]             addr_idx;
	logic                   wr_hit;
	logic                   rd_hit;
	logic [GPCFG_NREG-1:0]  wr_sel;
	logic [GPCFG_NREG-1:0]  rd_sel;

	// Serial engine running in a defined mode
	logic                   serial_on;

	// Field views, one bit per pin
	logic [GPCFG_NPIN-1:0]  fld_oe;
	logic [GPCFG_NPIN-1:0]  fld_pullup;
	logic [GPCFG_NPIN-1:0]  fld_od;
	logic [GPCFG_NPIN-1:0]  fld_sink;
	logic [GPCFG_NPIN-1:0]  fld_ttl;
	logic [GPCFG_NPIN-1:0]  fld_int_low;
	logic [GPCFG_NPIN-1:0]  fld_int_en;
	logic [GPCFG_NPIN-1:0]  fld_top;

	// Drive before the open-drain stage
	logic [GPCFG_NPIN-1:0]  drv_val;
	logic [GPCFG_NPIN-1:0]  drv_oe;
	logic [GPCFG_NPIN-1:0]  drv_od;
	logic [GPCFG_NPIN-1:0]  eng_owns;

	genvar i;

	// Address decode over the contiguous block of offsets
	assign rel_addr  = reg_addr - PORT0_PIN7_CONFIG;
	assign addr_hit  = (reg_addr >= PORT0_PIN7_CONFIG) && (reg_addr <= PORT2_PAIR_CONFIG);
	assign addr_idx  = rel_addr[3:0];
	// Strobes qualified by the decode; unmapped accesses do nothing
	assign wr_hit    = reg_wr && addr_hit;
	assign rd_hit    = reg_rd && addr_hit;
	// Mode 11 is reserved and treated as disabled
	assign serial_on = (serial_mode == COMM_MASTER) || (serial_mode == COMM_SLAVE);

	// One-hot register selects, so no index ever leaves the array
	generate
		for (i = 0; i < GPCFG_NREG; i++)
		begin : g_sel
			assign wr_sel[i] = wr_hit && (addr_idx == 4'(i));
			assign rd_sel[i] = rd_hit && (addr_idx == 4'(i));
		end
	endgenerate

	// Next register values; reserved bits never store a one
	always_comb
	begin
		for (int k = 0; k < GPCFG_NREG; k++)
		begin
			cfg_nxt[k] = cfg_r[k];
			if (wr_sel[k])
				cfg_nxt[k] = reg_wdata & GPCFG_MASK[k];
		end
	end

	// Read data stands one cycle, then zero so slaves can be ORed
	always_comb
	begin
		rdata_nxt = 8'h00;
		for (int k = 0; k < GPCFG_NREG; k++)
		begin
			if (rd_sel[k])
				rdata_nxt = rdata_nxt | cfg_r[k];
		end
	end

	// Registers only; a write lands on the edge where it is seen
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			for (int k = 0; k < GPCFG_NREG; k++)
				cfg_r[k] <= GPCFG_RESET;
			rdata_r <= 8'h00;
		end
		else
		begin
			cfg_r   <= cfg_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Read data straight from flip-flops
	assign reg_rdata = rdata_r;

	// Field views; both port 2 pins read the last register
	generate
		for (i = IDX_PORT0_PIN7; i < GPCFG_NPIN; i++)
		begin : g_field
			localparam int RI = (i < IDX_PORT2_PIN1) ? i : IDX_PORT2_PIN0;

			// Output enable
			assign fld_oe[i]      = cfg_r[RI][F_OE];

			// Port1_pin1 has no pull-up bit and borrows port1_pin0's
			assign fld_pullup[i]  = (i == IDX_PORT1_PIN1)
				? cfg_r[IDX_PORT1_PIN0][F_PULLUP] : cfg_r[RI][F_PULLUP];

			// Open drain and high sink
			assign fld_od[i]      = cfg_r[RI][F_OPEN_DRAIN];
			assign fld_sink[i]    = cfg_r[RI][F_HIGH_SINK];

			// Threshold select where the register has one
			assign fld_ttl[i]     = cfg_r[RI][F_TTL];

			// Interrupt enable and polarity
			assign fld_int_low[i] = cfg_r[RI][F_INT_LOW];
			assign fld_int_en[i]  = cfg_r[RI][F_INT_EN];

			// Top bit: clock output or serial-use flag
			assign fld_top[i]     = cfg_r[RI][F_TOP];
		end
	endgenerate

	// Per-pin drive and pad controls
	generate
		for (i = 0; i < GPCFG_NPIN; i++)
		begin : g_pin
			// Engine lane; pins outside the engine point at lane 0
			localparam int SI = ((i >= ENG_FIRST) && (i <= ENG_LAST)) ? (i - ENG_FIRST) : 0;
			gpcfg_src_type src;

			// Port1_pin3 follows the engine alone; pins 4 to 6 need their flag
			assign eng_owns[i] = (i == IDX_PORT1_PIN3) ? serial_on
				: ((i > ENG_FIRST) && (i <= ENG_LAST)) ? (serial_on & fld_top[i])
				: 1'b0;

			// Engine first, then clock output, else firmware
			always_comb
			begin
				src = SRC_FIRMWARE;
				if (eng_owns[i])
					src = SRC_ENGINE;
				else if ((i == IDX_PORT1_PIN2) && fld_top[i])
					src = SRC_CLOCK;
			end

			// Value and direction per source
			always_comb
			begin
				drv_val[i] = pin_data[i];
				drv_oe[i]  = fld_oe[i];
				case (src)
					SRC_ENGINE:
					begin
						drv_val[i] = serial_out[SI];
						// Port1_pin4 direction stays with firmware in both modes
						if ((i == IDX_PORT1_PIN3) || (i == IDX_PORT1_PIN5) || (i == IDX_PORT1_PIN6))
							drv_oe[i] = serial_oe[SI];
					end
					SRC_CLOCK:
					begin
						drv_val[i] = clock_select_out;
						drv_oe[i]  = 1'b1;
					end
					default:
					begin
						drv_val[i] = pin_data[i];
						drv_oe[i]  = fld_oe[i];
					end
				endcase
			end

			// Port1_pin0 has no high-side driver at all
			assign drv_od[i] = (i == IDX_PORT1_PIN0) ? 1'b1 : fld_od[i];

			// Open drain releases on one, pulls low on zero
			assign pin_oe[i]        = drv_oe[i] & ~(drv_od[i] & drv_val[i]);
			assign pin_out[i]       = drv_od[i] ? 1'b0 : drv_val[i];
			// Pad controls hold the same in serial use
			assign pin_pullup[i]    = fld_pullup[i];
			assign pin_ttl[i]       = ((i >= IDX_PORT1_PIN3) && (i <= IDX_PORT1_PIN7))
				? 1'b1 : fld_ttl[i];
			assign pin_high_sink[i] = fld_sink[i];
		end
	endgenerate

	// Edge views; a pin driven as output still counts
	assign rise_seen = ~prev_r & pin_in;
	assign fall_seen = prev_r & ~pin_in;

	// Next detector state; polarity picks the edge per pin
	always_comb
	begin
		prev_nxt = pin_in;
		for (int p = 0; p < GPCFG_NPIN; p++)
		begin
			if (fld_int_low[p])
				irq_nxt[p] = fld_int_en[p] & fall_seen[p];
			else
				irq_nxt[p] = fld_int_en[p] & rise_seen[p];
		end
	end

	// Detector flops; enables are off at reset, so no false edge
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			prev_r <= '0;
			irq_r  <= '0;
		end
		else
		begin
			prev_r <= prev_nxt;
			irq_r  <= irq_nxt;
		end
	end

	// One-cycle pulses straight from flip-flops
	assign pin_irq = irq_r;
endmodule : gpcfg_top

// ===== test/gpcfg_pins.sv
// Pad model of the board wiring behind each pin
`timescale 1ns/1ns
module gpcfg_pins (
	input  wire logic [10:0] pin_out,
	input  wire logic [10:0] pin_oe,
	input  wire logic [10:0] pin_pullup,
	input  wire logic [10:0] ext,
	output logic      [10:0] pin_in
);
	// Released pin falls to pull-up, else the outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup | ext));
endmodule : gpcfg_pins

// ===== test/gpcfg_properties.sv
// Port checks for the pin configuration block
`timescale 1ns/1ns
module gpcfg_properties (
	input wire logic        clock, resetn, reg_rd,
	input wire logic [7:0]  reg_addr, reg_rdata,
	input wire logic [1:0]  serial_mode,
	input wire logic [3:0]  serial_oe,
	input wire logic [10:0] pin_data, pin_in, pin_out, pin_oe, pin_pullup, pin_ttl, pin_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	AST_P10_LOW: assert property (pin_out[1] == 1'b0)
		else $error("p10 high");
	AST_P10_OD: assert property (pin_oe[1] |-> !pin_data[1])
		else $error("p10 drives one");
	AST_TTL: assert property (pin_ttl[8:4] == 5'h1F)
		else $error("ttl lost");
	AST_PULLUP: assert property (pin_pullup[1] == pin_pullup[2])
		else $error("pullups split");
	AST_ENG_OE: assert property (serial_mode inside {2'h1, 2'h2} && pin_oe[4] |-> serial_oe[0])
		else $error("p13 oe");
	AST_IRQ: assert property (pin_irq[0] |-> $past(pin_in[0]) != $past(pin_in[0], 2))
		else $error("irq no edge");
	AST_RSVD: assert property (reg_rd && reg_addr == 8'h0C |=> (reg_rdata & 8'h88) == 8'h00)
		else $error("rsvd set");
	AST_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("rdata idle");
endmodule : gpcfg_properties
bind gpcfg_top gpcfg_properties u_prop (.clock, .resetn, .reg_rd, .reg_addr, .reg_rdata,
	.serial_mode, .serial_oe, .pin_data, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_ttl, .pin_irq);

// ===== test/gpcfg_top_test.sv
// Self-checking bench for the pin configuration block
`timescale 1ns/1ns
module gpcfg_top_test;
	import gpcfg_pkg::*;
	logic        clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, clock_select_out = 0;
	logic [7:0]  reg_addr = '0, reg_wdata = '0, reg_rdata;
	logic [1:0]  serial_mode = '0;
	logic [3:0]  serial_out = '0, serial_oe = '0;
	logic [10:0] pin_data = '0, ext = '0, pin_in, pin_out, pin_oe, pin_pullup, pin_ttl, pin_irq;
	logic [10:0] pin_high_sink;
	int          num_errors = 0, total_checks = 0;
	always #10 clock = ~clock;
	gpcfg_top dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pin_data, .pin_in, .serial_mode, .serial_out, .serial_oe, .clock_select_out,
		.pin_out, .pin_oe, .pin_pullup, .pin_ttl, .pin_high_sink, .pin_irq);
	gpcfg_pins pins (.pin_out, .pin_oe, .pin_pullup, .ext, .pin_in);
	task chk(input logic [10:0] s, input logic [10:0] e, input string n);
		total_checks++;
		num_errors += int'(s !== e);
		if (s !== e) $display("wrong value %s expected %h seen %h", n, e, s);
	endtask : chk
	// Bus cycles: one strobe cycle each
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clock) reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clock) reg_rd <= 1'b0;
		#1 chk(11'(reg_rdata), 11'(e), "rdata");
	endtask : rd
	task t_regs;
		for (int i = 0; i < GPCFG_NREG; i++)
		begin
			rd(8'(8'h0C + i), 8'h00);
			wr(8'(8'h0C + i), 8'hFF);
			rd(8'(8'h0C + i), GPCFG_MASK[i]);
			wr(8'(8'h0C + i), 8'h00);
		end
		wr(8'h30, 8'hFF);
		rd(8'h30, 8'h00);
	endtask : t_regs
	// Open-drain-only pin and its shared pull-up
	task t_p10;
		wr(8'h0D, 8'h03);
		pin_data <= 11'h002;
		#1 chk({pin_oe[1], pin_pullup[2:1]}, 3'h3, "p10 one");
		@(posedge clock) pin_data <= 11'h000;
		#1 chk({pin_oe[1], pin_out[1]}, 2'h2, "p10 zero");
		wr(8'h0D, 8'h00);
		#1 chk({pin_oe[1], pin_pullup[2:1]}, 3'h0, "p10 off");
	endtask : t_p10
	// Port 2 pair follows one register; fixed threshold on port 1 upper pins
	task t_pair;
		wr(8'h15, 8'h1B);
		pin_data <= 11'h600;
		#1 chk({pin_ttl[10:9], pin_high_sink[10:9], pin_pullup[10:9]}, 6'h3F, "p2 pads");
		chk({pin_oe[10:9], pin_out[10:9]}, 4'hF, "p2 drive");
		chk({pin_ttl[8:4], pin_ttl[0]}, 6'h3E, "ttl");
		wr(8'h15, 8'h00);
		pin_data <= 11'h000;
		#1 chk({pin_high_sink[10:9], pin_oe[10:9]}, 4'h0, "p2 off");
	endtask : t_pair
	// Slave mode: engine sets port1_pin6 direction, firmware keeps pin4 input
	task t_slave;
		wr(8'h13, 8'h80);
		wr(8'h11, 8'h80);
		serial_mode <= COMM_SLAVE;
		{serial_oe, serial_out} <= 8'h88;
		#1 chk({pin_oe[7], pin_out[7], pin_oe[5]}, 3'h6, "slave");
		@(posedge clock) serial_mode <= COMM_OFF;
	endtask : t_slave
	// Engine takeover, per-pin flag and the pin without auto direction
	task t_serial;
		wr(8'h10, 8'h01);
		pin_data <= 11'h010;
		#1 chk({pin_oe[4], pin_out[4]}, 2'h3, "p13 gpio");
		@(posedge clock) serial_mode <= COMM_MASTER;
		#1 chk(pin_oe[4], 1'b0, "p13 eng");
		wr(8'h12, 8'h8A);
		{serial_oe, serial_out} <= 8'h44;
		#1 chk({pin_oe[6], pin_out[6], pin_pullup[6], pin_high_sink[6]}, 4'hF, "p15 eng");
		wr(8'h11, 8'h81);
		#1 chk(pin_oe[5], 1'b1, "p14 oe");
		@(posedge clock) serial_mode <= COMM_OFF;
		#1 chk(pin_oe[6], 1'b0, "p15 gpio");
	endtask : t_serial
	task t_clk;
		wr(8'h0F, 8'h80);
		clock_select_out <= 1'b1;
		#1 chk({pin_oe[3], pin_out[3]}, 2'h3, "clk on");
		wr(8'h0F, 8'h00);
		#1 chk(pin_oe[3], 1'b0, "clk off");
	endtask : t_clk
	// Rising, falling, then masked edge on port0_pin7
	task t_irq;
		wr(8'h0C, 8'h40);
		ext <= 11'h001;
		@(posedge clock) #1 chk(pin_irq[0], 1'b1, "irq rise");
		wr(8'h0C, 8'h60);
		ext <= 11'h000;
		@(posedge clock) #1 chk(pin_irq[0], 1'b1, "irq fall");
		wr(8'h0C, 8'h00);
		ext <= 11'h001;
		@(posedge clock) #1 chk(pin_irq[0], 1'b0, "irq off");
	endtask : t_irq
	task end_sim;
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		t_regs;
		t_p10;
		t_pair;
		t_serial;
		t_slave;
		t_clk;
		t_irq;
		end_sim;
	end
endmodule : gpcfg_top_test
